// file: hdl/rlx_exec.sv
// Execution datapath for return-with-immediate and rotate-left-via-carry
`timescale 1ns/10ps
`default_nettype none
module rlx_exec
  import rlx_pkg::*;
#(
  parameter int unsigned CYCLE_DIV = rlx_pkg::CYC_DIV
)
(
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  // Instruction from decoder
  input  wire rlx_pkg::rlx_instr_t          instr,
  input  wire logic                         instr_valid,
  output logic                              instr_ready,
  output logic                              instr_done,
  // Accumulator and carry preload from the rest of the core
  input  wire logic                         acc_load,
  input  wire logic [rlx_pkg::DATA_W-1:0]   acc_load_data,
  input  wire logic                         carry_load,
  input  wire logic                         carry_load_data,
  // Architectural state
  output logic      [rlx_pkg::DATA_W-1:0]   acc,
  output logic                              carry,
  // Register file write port
  output rlx_pkg::rlx_file_wr_t             file_wr,
  // Return stack and program counter
  input  wire logic [rlx_pkg::PC_W-1:0]     stack_top_entry,
  output logic                              stack_pop,
  output logic                              pc_load,
  output logic      [rlx_pkg::PC_W-1:0]     pc_value
);
  import rlx_pkg::*;

  logic [CNT_W-1:0]  div_cnt;
  logic              cyc_en;
  rlx_state_t        state;
  logic              accept;
  logic              acc_ret;
  logic              acc_rot;
  logic [DATA_W-1:0] rot_result;
  logic              rot_carry;

  // Return completes one instruction cycle after it is taken
  localparam int RET_LAT = int'(CYCLE_DIV);

  // Instruction cycle strobe; all execution is aligned to it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_cnt <= '0;
    end else if (div_cnt == CNT_W'(CYCLE_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + CNT_W'(1);
    end
  end
  assign cyc_en = (div_cnt == CNT_W'(CYCLE_DIV - 1));

  assign instr_ready = cyc_en && (state == RLX_ST_IDLE);
  assign accept      = instr_valid && instr_ready;
  assign acc_ret     = accept && (instr.op == RLX_OP_RETLIT);
  assign acc_rot     = accept && (instr.op == RLX_OP_ROTL);

  rlx_rotl u_rotl (
    .operand   (instr.file_operand),
    .carry_in  (carry),
    .result    (rot_result),
    .carry_out (rot_carry)
  );

  // Second cycle of the return is spent popping the stack
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= RLX_ST_IDLE;
    end else begin
      case (state)
        RLX_ST_IDLE: begin
          if (acc_ret) begin
            state <= RLX_ST_RET_2;
          end
        end
        RLX_ST_RET_2: begin
          if (cyc_en) begin
            state <= RLX_ST_IDLE;
          end
        end
        default: state <= RLX_ST_IDLE;
      endcase
    end
  end

  // Accumulator; core results win over the preload port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc <= ACC_RESET;
    end else if (acc_ret) begin
      acc <= instr.literal;
    end else if (acc_rot && !instr.dest_file) begin
      acc <= rot_result;
    end else if (acc_load) begin
      acc <= acc_load_data;
    end
  end

  // Carry is touched only by the rotate and the preload port; the rotate wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      carry <= CARRY_RESET;
    end else if (acc_rot) begin
      carry <= rot_carry;
    end else if (carry_load) begin
      carry <= carry_load_data;
    end
  end

  // Write-back goes out as a one-cycle strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      file_wr <= '0;
    end else begin
      file_wr.wr_en <= acc_rot && instr.dest_file;
      if (acc_rot) begin
        file_wr.addr <= instr.file_addr;
        file_wr.data <= rot_result;
      end
    end
  end

  // Stack pop and PC reload at the end of the return
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stack_pop <= 1'b0;
      pc_load   <= 1'b0;
      pc_value  <= '0;
    end else begin
      stack_pop <= (state == RLX_ST_RET_2) && cyc_en;
      pc_load   <= (state == RLX_ST_RET_2) && cyc_en;
      if ((state == RLX_ST_RET_2) && cyc_en) begin
        pc_value <= stack_top_entry;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= acc_rot || (accept && instr.op == RLX_OP_NONE) ||
                    ((state == RLX_ST_RET_2) && cyc_en);
    end
  end

  property p_ret_acc;
    @(posedge sys_clk) disable iff (reset)
    acc_ret |=> acc == $past(instr.literal);
  endproperty
  a_ret_acc: assert property (p_ret_acc) else $error("accumulator missed immediate");

  property p_pop_pc;
    @(posedge sys_clk) disable iff (reset)
    stack_pop |-> pc_load && pc_value == $past(stack_top_entry);
  endproperty
  a_pop_pc: assert property (p_pop_pc) else $error("pc not loaded from stack top");

  property p_ret_two_cycles;
    @(posedge sys_clk) disable iff (reset)
    acc_ret |=> (!instr_done && !stack_pop) ##RET_LAT (instr_done && stack_pop);
  endproperty
  a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("return not two cycles");

  property p_ret_carry;
    @(posedge sys_clk) disable iff (reset)
    (state == RLX_ST_RET_2) && !carry_load |=> $stable(carry);
  endproperty
  a_ret_carry: assert property (p_ret_carry) else $error("return touched carry");

  property p_ret_flags;
    @(posedge sys_clk) disable iff (reset)
    acc_ret && !carry_load |=> $stable(carry);
  endproperty
  a_ret_flags: assert property (p_ret_flags) else $error("return changed carry when taken");

  property p_rot_value;
    @(posedge sys_clk) disable iff (reset)
    acc_rot && !instr.dest_file |=>
      acc == {$past(instr.file_operand[6:0]), $past(carry)} && carry == $past(instr.file_operand[7]);
  endproperty
  a_rot_value: assert property (p_rot_value) else $error("rotate result wrong");

  property p_rot_file;
    @(posedge sys_clk) disable iff (reset)
    acc_rot && instr.dest_file && !acc_load |=>
      file_wr.wr_en && file_wr.addr == $past(instr.file_addr) && acc == $past(acc) &&
      file_wr.data == {$past(instr.file_operand[6:0]), $past(carry)};
  endproperty
  a_rot_file: assert property (p_rot_file) else $error("rotate write-back wrong");

  property p_rot_acc_only;
    @(posedge sys_clk) disable iff (reset)
    acc_rot && !instr.dest_file |=> !file_wr.wr_en;
  endproperty
  a_rot_acc_only: assert property (p_rot_acc_only) else $error("rotate wrote file for d=0");

  property p_rot_one_cycle;
    @(posedge sys_clk) disable iff (reset)
    acc_rot |=> instr_done && !stack_pop;
  endproperty
  a_rot_one_cycle: assert property (p_rot_one_cycle) else $error("rotate not single cycle");

  c_ret: cover property (@(posedge sys_clk) disable iff (reset) acc_ret ##[1:16] stack_pop);
  c_rot_acc: cover property (@(posedge sys_clk) disable iff (reset) acc_rot && !instr.dest_file);
  c_rot_file: cover property (@(posedge sys_clk) disable iff (reset) acc_rot && instr.dest_file && carry);
  c_idle_op: cover property (@(posedge sys_clk) disable iff (reset) accept && instr.op == RLX_OP_NONE);
  c_ret_rot: cover property (@(posedge sys_clk) disable iff (reset) stack_pop ##[1:16] acc_rot);
endmodule // rlx_exec
`default_nettype wire

// file: hdl/rlx_pkg.sv
// Shared types and constants for the return-literal and rotate-left datapath
package rlx_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FILE_ADDR_W = 7;
  localparam int unsigned PC_W        = 15;
  localparam int unsigned CYC_DIV     = 4;
  localparam int unsigned CNT_W       = 3;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic        CARRY_RESET = 1'b0;
  localparam int unsigned MSB_POS     = 7;

  typedef enum logic [1:0] {
    RLX_OP_NONE  = 2'h0,
    RLX_OP_RETLIT = 2'h1,
    RLX_OP_ROTL  = 2'h2
  } rlx_op_t;

  typedef enum logic [1:0] {
    RLX_ST_IDLE   = 2'h0,
    RLX_ST_RET_2  = 2'h1
  } rlx_state_t;

  typedef struct packed {
    rlx_op_t                op;
    logic [DATA_W-1:0]      literal;
    logic [FILE_ADDR_W-1:0] file_addr;
    logic                   dest_file;
    logic [DATA_W-1:0]      file_operand;
  } rlx_instr_t;

  typedef struct packed {
    logic                   wr_en;
    logic [FILE_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]      data;
  } rlx_file_wr_t;
endpackage : rlx_pkg

// file: hdl/rlx_rotl.sv
// Rotate one byte left through the carry flag
`timescale 1ns/10ps
`default_nettype none
module rlx_rotl
  import rlx_pkg::*;
(
  // Operand
  input  wire logic [rlx_pkg::DATA_W-1:0] operand,
  input  wire logic                       carry_in,
  // Result
  output logic      [rlx_pkg::DATA_W-1:0] result,
  output logic                            carry_out
);
  assign result    = {operand[DATA_W-2:0], carry_in};
  assign carry_out = operand[MSB_POS];
endmodule // rlx_rotl
`default_nettype wire

// file: hdl/rlx_unused_placeholder_none.sv
// Intentionally empty design unit list
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: tb/rlx_partner.sv
// Model of the register file and return stack beside the datapath
`timescale 1ns/10ps
`default_nettype none
module rlx_partner
  import rlx_pkg::*;
(
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             reset,
  // Register file
  input  wire rlx_pkg::rlx_file_wr_t            file_wr,
  input  wire logic [rlx_pkg::FILE_ADDR_W-1:0]  rd_addr,
  output logic      [rlx_pkg::DATA_W-1:0]       rd_data,
  // Return stack
  input  wire logic                             stack_pop,
  output logic      [rlx_pkg::PC_W-1:0]         stack_top_entry
);
  import rlx_pkg::*;
  logic [7:0] mem [128];
  logic [2:0] sp;
  // Top bit set so every operand exercises the carry out
  initial for (int i = 0; i < 128; i++) mem[i] = {1'b1, 7'(i)};
  always @(posedge sys_clk) begin
    if (file_wr.wr_en) begin
      mem[file_wr.addr] <= file_wr.data;
    end
  end
  always @(posedge sys_clk) begin
    if (reset) begin
      sp <= 3'h7;
    end else if (stack_pop) begin
      sp <= sp - 3'h1;
    end
  end
  assign rd_data         = mem[rd_addr];
  assign stack_top_entry = {12'h5a0, sp};
endmodule // rlx_partner
`default_nettype wire

// file: tb/rlx_exec_tb_top.sv
// Self-checking bench for the return and rotate datapath
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end
module rlx_exec_tb_top;
  import rlx_pkg::*;
  localparam int CYC = 4;
  logic         sys_clk, reset, instr_valid, instr_ready, instr_done;
  rlx_instr_t   instr;
  rlx_file_wr_t file_wr;
  logic [7:0]   acc, rd_data;
  logic         carry, stack_pop, pc_load;
  logic [14:0]  stack_top_entry, pc_value;
  int           fail_count = 0;
  int           n_checks = 0;

  rlx_exec #(.CYCLE_DIV(CYC)) DUT (.sys_clk(sys_clk), .reset(reset), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_done(instr_done),
    .acc_load(1'b0), .acc_load_data(8'h00), .carry_load(1'b0), .carry_load_data(1'b0),
    .acc(acc), .carry(carry), .file_wr(file_wr), .stack_top_entry(stack_top_entry),
    .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value));
  rlx_partner P (.sys_clk(sys_clk), .reset(reset), .file_wr(file_wr), .rd_addr(instr.file_addr),
    .rd_data(rd_data), .stack_pop(stack_pop), .stack_top_entry(stack_top_entry));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Entered at a falling edge; returns at the falling edge after acceptance
  task automatic issue(input rlx_op_t op, input logic [7:0] lit, input logic [6:0] a, input logic d);
    int k;
    k = 0;
    // Address goes out early so the partner's read data settle before the strobe
    instr.file_addr = a;
    do begin
      @(negedge sys_clk);
      k++;
    end while (instr_ready !== 1'b1 && k < 20);
    `CHK("ready", 1'b1, instr_ready)
    instr.op        = op;
    instr.literal   = lit;
    instr.dest_file = d;
    instr.file_operand = rd_data;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
  endtask

  task automatic t_rot(input logic [6:0] a, input logic d, input logic [7:0] er, input logic ec);
    logic [7:0] a0;
    a0 = acc;
    issue(RLX_OP_ROTL, 8'h00, a, d);
    `CHK("done", 1'b1, instr_done)
    `CHK("carry", ec, carry)
    `CHK("acc", d ? a0 : er, acc)
    `CHK("wr_en", d, file_wr.wr_en)
    if (d) `CHK("wr_addr", a, file_wr.addr)
    if (d) `CHK("wr_data", er, file_wr.data)
    @(negedge sys_clk);
    `CHK("done_pulse", 1'b0, instr_done)
    `CHK("file", d ? er : {1'b1, a}, P.mem[a])
    $display("rotate test at %h done", a);
  endtask

  task automatic t_ret(input logic [7:0] lit, input logic [14:0] top, input logic ec);
    int k;
    issue(RLX_OP_RETLIT, lit, 7'h00, 1'b0);
    `CHK("acc", lit, acc)
    `CHK("pop_early", 1'b0, stack_pop)
    k = 1;
    while (stack_pop !== 1'b1 && k < 12) begin
      @(negedge sys_clk);
      k++;
      `CHK("ready_busy", 1'b0, instr_ready)
    end
    `CHK("cycles", CYC + 1, k)
    `CHK("pc_load", 1'b1, pc_load)
    `CHK("pc", top, pc_value)
    `CHK("done", 1'b1, instr_done)
    `CHK("carry", ec, carry)
    `CHK("wr_en", 1'b0, file_wr.wr_en)
    @(negedge sys_clk);
    $display("return test with %h done", lit);
  endtask

  // Empty operation only completes; no state may move
  task automatic t_none;
    logic [7:0] a0;
    logic       c0;
    a0 = acc;
    c0 = carry;
    issue(RLX_OP_NONE, 8'h5a, 7'h01, 1'b1);
    `CHK("done", 1'b1, instr_done)
    `CHK("acc", a0, acc)
    `CHK("carry", c0, carry)
    `CHK("wr_en", 1'b0, file_wr.wr_en)
    `CHK("pop", 1'b0, stack_pop)
    @(negedge sys_clk);
    $display("idle operation test done");
  endtask

  initial begin
    reset = 1'b1;
    instr = '0;
    instr_valid = 1'b0;
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    t_rot(7'h73, 1'b0, 8'he6, 1'b1);
    t_rot(7'h00, 1'b1, 8'h01, 1'b1);
    t_rot(7'h7f, 1'b1, 8'hff, 1'b1);
    t_ret(8'hff, 15'h2d07, 1'b1);
    t_ret(8'h00, 15'h2d06, 1'b1);
    t_rot(7'h40, 1'b0, 8'h81, 1'b1);
    t_none();
    end_of_test();
  end

  // Whole sequence needs about 60 cycles; generous margin
  initial begin
    #(2000 * 5);
    fail_count++;
    end_of_test();
  end
endmodule // rlx_exec_tb_top
`default_nettype wire
